//--- common/smc_pkg.sv
// Constants and types of the stop mode controller
//
// Overview of operation
// - Stop disabled: STOP gives illegal opcode reset
// - Debug enabled: light stop, debug clocks run
// - Both voltage bits: light stop, regulator active
// - Otherwise select bit picks light or deep
// - Any stop halts bus and CPU clocks
// - Light stop keeps all state and pins
// - Light stop exits on reset pin or interrupts
// - Pin exit resets; interrupt exit takes vector
// - Both voltage bits keep regulator active
// - Converter runs in stop only with async clock, detector
// - Debug enable keeps debug clocks, full regulation
// - Status memory commands refused with error
// - BACKGROUND wakes to debug when enabled
// - Deep stop powers down, latches pin controls
// - Deep stop exits on pin or enabled counter
// - Deep wake acts as power-on reset
// - Deep wake flag and latches held until ack
// - Opened latches follow current port values in run
// - Peripheral clocks stop in every stop
// - Detector stop bit turns deep into light
// - Reference clock runs in stop only when both enabled
package smc_pkg;
  typedef enum logic [1:0] {SMC_RUN, SMC_LIGHT, SMC_DEEP} smc_state_type;
  typedef enum logic [2:0] {LVL_ILLEGAL, LVL_LIGHT_DBG, LVL_LIGHT_REG, LVL_LIGHT,
    LVL_DEEP} smc_level_type;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PWR2 = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam int CTRL_W = 9;
  localparam int CTRL_STOP_EN = 0;
  localparam int CTRL_LOW_VOLTAGE_DETECT_ENABLE = 1;
  localparam int CTRL_LOW_VOLTAGE_DETECT_STOP_ENABLE = 2;
  localparam int CTRL_LVD_RST = 3;
  localparam int CTRL_TRIP_SEL = 4;
  localparam int CTRL_REF_EN = 5;
  localparam int CTRL_REF_STOP = 6;
  localparam int CTRL_ADC_ASYNC = 7;
  localparam int CTRL_RTC_EN = 8;
  localparam logic [8:0] CTRL_RST = 9'h00e;
  localparam int PWR2_SEL = 0;
  localparam int PWR2_FLAG = 1;
  localparam int PWR2_ACK = 2;
  localparam int STAT_LIGHT = 0;
  localparam int STAT_DEEP = 1;
  localparam int STAT_LATCH = 2;
  localparam int STAT_REG = 3;
  localparam int STAT_DBG = 4;

  // ---------------------------------------------------------------
  // Wake sources and pins
  // ---------------------------------------------------------------
  localparam int WAKE_W = 6;
  localparam int IRQ_RTC = 0;
  localparam int PIN_W = 8;
  localparam logic SYNC_RST = 1'b1;
endpackage

//--- common/smc_sel_if.sv
// Stop level selection signals between controller and decoder
`timescale 1ns/100ps
interface smc_sel_if;
  logic stop_en;
  logic dbg_en;
  logic low_voltage_detect_enable;
  logic low_voltage_detect_stop_enable;
  logic pd_sel;
  smc_pkg::smc_level_type level;
  modport ctrl (output stop_en, dbg_en, low_voltage_detect_enable, low_voltage_detect_stop_enable, pd_sel, input level);
  modport dec (input stop_en, dbg_en, low_voltage_detect_enable, low_voltage_detect_stop_enable, pd_sel, output level);
endinterface

//--- rtl/smc_mode_sel.sv
// Stop level decoder from the configuration bits
`timescale 1ns/100ps
module smc_mode_sel (
  smc_sel_if.dec sel
);
  import smc_pkg::*;

  function automatic smc_level_type decode_level(input logic stop_en, input logic dbg_en,
      input logic low_voltage_detect_enable, input logic low_voltage_detect_stop_enable, input logic pd_sel);
    smc_level_type lvl;
    if (!stop_en) begin
      lvl = LVL_ILLEGAL;
    end else if (dbg_en) begin
      lvl = LVL_LIGHT_DBG;
    end else if (low_voltage_detect_enable && low_voltage_detect_stop_enable) begin
      lvl = LVL_LIGHT_REG;
    end else if (pd_sel && !low_voltage_detect_stop_enable) begin
      lvl = LVL_DEEP;
    end else begin
      lvl = LVL_LIGHT;
    end
    return lvl;
  endfunction

  assign sel.level = decode_level(sel.stop_en, sel.dbg_en, sel.low_voltage_detect_enable, sel.low_voltage_detect_stop_enable, sel.pd_sel);
endmodule

//--- rtl/smc_stop_ctrl.sv
// Stop mode controller with AHB-Lite register slave
`timescale 1ns/100ps
module smc_stop_ctrl (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic hreadyout_out,
  output logic hresp_out,
  output logic [31:0] hrdata_out,
  input wire logic stop_exec_in,
  input wire logic debug_mode_enable_in,
  input wire logic reset_pin_n_in,
  input wire logic [smc_pkg::WAKE_W-1:0] wake_irq_in,
  input wire logic dbg_mem_cmd_in,
  input wire logic dbg_bgnd_cmd_in,
  input wire logic [smc_pkg::PIN_W-1:0] pin_ctrl_in,
  output logic [smc_pkg::PIN_W-1:0] pin_ctrl_out,
  output logic pin_latch_out,
  output logic bus_clk_run_out,
  output logic cpu_clk_run_out,
  output logic periph_clk_run_out,
  output logic debug_clk_run_out,
  output logic regulator_active_out,
  output logic adc_run_out,
  output logic ref_clk_run_out,
  output logic power_down_out,
  output logic illegal_reset_out,
  output logic sys_reset_out,
  output logic por_reset_out,
  output logic irq_wake_out,
  output logic bkgd_enter_out,
  output logic dbg_mem_grant_out,
  output logic dbg_err_out,
  output logic lvd_reset_en_out,
  output logic lvd_trip_sel_out
);
  import smc_pkg::*;

  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] ofs);
    return addr == ofs;
  endfunction

  smc_state_type state_r, state_nxt;
  smc_level_type level_r, level_nxt;
  logic dbg_keep_r, dbg_keep_nxt;
  logic reg_keep_r, reg_keep_nxt;
  logic adc_keep_r, adc_keep_nxt;
  logic ref_keep_r, ref_keep_nxt;
  logic [CTRL_W-1:0] ctrl_r;
  logic pd_sel_r;
  logic pd_flag_r;
  logic pin_latch_r;
  logic [PIN_W-1:0] pin_ctrl_r;
  logic rst_pin_n_s;
  logic rst_pin_prev_r;
  logic pin_evt;
  logic any_irq;
  logic stop_go;
  logic enter_deep;
  logic light_exit_rst;
  logic light_exit_irq;
  logic bkgd_wake;
  logic deep_wake;
  logic stopped_nxt;
  logic lvd_stop_on;
  logic hreadyout_r;
  logic hresp_r;
  logic [31:0] hrdata_r;
  logic [31:0] rd_word;
  logic wr_pend_r;
  logic [7:0] wr_addr_r;
  logic addr_ok;
  logic ctrl_wr;
  logic pwr2_wr;
  logic ack_wr;
  logic bus_clk_r, cpu_clk_r, periph_clk_r, dbg_clk_r;
  logic reg_act_r, adc_run_r, ref_run_r, pdown_r;
  logic illegal_r, sys_rst_r, por_r, irq_wake_r, bkgd_r, grant_r, dbg_err_r;

  // ---------------------------------------------------------------
  // Pin synchroniser and level decoder
  // ---------------------------------------------------------------
  smc_sel_if sel_if ();

  smc_sync u_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .d_in(reset_pin_n_in),
    .q_out(rst_pin_n_s)
  );

  smc_mode_sel u_sel (
    .sel(sel_if.dec)
  );

  assign sel_if.stop_en = ctrl_r[CTRL_STOP_EN];
  assign sel_if.dbg_en = debug_mode_enable_in;
  assign sel_if.low_voltage_detect_enable = ctrl_r[CTRL_LOW_VOLTAGE_DETECT_ENABLE];
  assign sel_if.low_voltage_detect_stop_enable = ctrl_r[CTRL_LOW_VOLTAGE_DETECT_STOP_ENABLE];
  assign sel_if.pd_sel = pd_sel_r;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rst_pin_prev_r <= 1'b1;
    end else begin
      rst_pin_prev_r <= rst_pin_n_s;
    end
  end

  // ---------------------------------------------------------------
  // Wake and entry events
  // ---------------------------------------------------------------
  assign pin_evt = rst_pin_prev_r && !rst_pin_n_s;
  assign any_irq = |wake_irq_in;
  assign lvd_stop_on = ctrl_r[CTRL_LOW_VOLTAGE_DETECT_ENABLE] && ctrl_r[CTRL_LOW_VOLTAGE_DETECT_STOP_ENABLE];
  assign stop_go = (state_r == SMC_RUN) && stop_exec_in && (sel_if.level != LVL_ILLEGAL);
  assign enter_deep = stop_go && (sel_if.level == LVL_DEEP);
  assign light_exit_rst = (state_r == SMC_LIGHT) && pin_evt;
  assign light_exit_irq = (state_r == SMC_LIGHT) && !pin_evt && any_irq;
  // Background wake only with debug kept
  assign bkgd_wake = (state_r == SMC_LIGHT) && !pin_evt && !any_irq && dbg_bgnd_cmd_in
    && dbg_keep_r;
  assign deep_wake = (state_r == SMC_DEEP)
    && (pin_evt || (wake_irq_in[IRQ_RTC] && ctrl_r[CTRL_RTC_EN]));

  // ---------------------------------------------------------------
  // Stop state machine
  // ---------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    level_nxt = level_r;
    dbg_keep_nxt = dbg_keep_r;
    reg_keep_nxt = reg_keep_r;
    adc_keep_nxt = adc_keep_r;
    ref_keep_nxt = ref_keep_r;
    case (state_r)
      SMC_RUN: begin
        // Level and options sampled at STOP
        if (stop_go) begin
          level_nxt = sel_if.level;
          state_nxt = enter_deep ? SMC_DEEP : SMC_LIGHT;
          dbg_keep_nxt = sel_if.level == LVL_LIGHT_DBG;
          reg_keep_nxt = (sel_if.level == LVL_LIGHT_DBG) || lvd_stop_on;
          // Converter needs async clock and detector
          adc_keep_nxt = lvd_stop_on && ctrl_r[CTRL_ADC_ASYNC];
          ref_keep_nxt = ctrl_r[CTRL_REF_EN] && ctrl_r[CTRL_REF_STOP];
        end
      end
      SMC_LIGHT: begin
        if (light_exit_rst || light_exit_irq || bkgd_wake) begin
          state_nxt = SMC_RUN;
        end
      end
      SMC_DEEP: begin
        if (deep_wake) begin
          state_nxt = SMC_RUN;
        end
      end
      default: begin
        state_nxt = SMC_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_r <= SMC_RUN;
      level_r <= LVL_ILLEGAL;
      dbg_keep_r <= 1'b0;
      reg_keep_r <= 1'b0;
      adc_keep_r <= 1'b0;
      ref_keep_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      level_r <= level_nxt;
      dbg_keep_r <= dbg_keep_nxt;
      reg_keep_r <= reg_keep_nxt;
      adc_keep_r <= adc_keep_nxt;
      ref_keep_r <= ref_keep_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Clock and power controls
  // ---------------------------------------------------------------
  // Built from next state so controls switch with the state itself
  assign stopped_nxt = state_nxt != SMC_RUN;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      bus_clk_r <= 1'b1;
      cpu_clk_r <= 1'b1;
      periph_clk_r <= 1'b1;
      dbg_clk_r <= 1'b1;
      reg_act_r <= 1'b1;
      adc_run_r <= 1'b1;
      ref_run_r <= 1'b1;
      pdown_r <= 1'b0;
    end else begin
      bus_clk_r <= !stopped_nxt;
      cpu_clk_r <= !stopped_nxt;
      periph_clk_r <= !stopped_nxt;
      // Debug clock kept in light stop entered with debug enabled
      dbg_clk_r <= !stopped_nxt || ((state_nxt == SMC_LIGHT) && dbg_keep_nxt);
      reg_act_r <= !stopped_nxt || ((state_nxt == SMC_LIGHT) && reg_keep_nxt);
      adc_run_r <= !stopped_nxt || ((state_nxt == SMC_LIGHT) && adc_keep_nxt);
      ref_run_r <= !stopped_nxt || ((state_nxt == SMC_LIGHT) && ref_keep_nxt);
      pdown_r <= state_nxt == SMC_DEEP;
    end
  end

  // ---------------------------------------------------------------
  // Pin latches and recovery flag
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pin_latch_r <= 1'b0;
    end else if (enter_deep || deep_wake) begin
      // Latch pin controls on deep entry
      pin_latch_r <= 1'b1;
    end else if (ack_wr) begin
      // Only the acknowledge opens the latches
      pin_latch_r <= 1'b0;
    end
  end

  // Pins follow port values only while open
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pin_ctrl_r <= '0;
    end else if (!pin_latch_r && !enter_deep && state_r == SMC_RUN) begin
      pin_ctrl_r <= pin_ctrl_in;
    end
  end

  // Flag set by deep wake wins over the acknowledge
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pd_flag_r <= 1'b0;
    end else if (deep_wake) begin
      pd_flag_r <= 1'b1;
    end else if (ack_wr) begin
      pd_flag_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Reset, wake and debug pulses
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      illegal_r <= 1'b0;
      sys_rst_r <= 1'b0;
      por_r <= 1'b0;
      irq_wake_r <= 1'b0;
      bkgd_r <= 1'b0;
      grant_r <= 1'b0;
      dbg_err_r <= 1'b0;
    end else begin
      // Illegal opcode reset instead of stop
      illegal_r <= (state_r == SMC_RUN) && stop_exec_in && (sel_if.level == LVL_ILLEGAL);
      sys_rst_r <= pin_evt && (state_r != SMC_DEEP);
      por_r <= deep_wake;
      irq_wake_r <= light_exit_irq;
      bkgd_r <= bkgd_wake || ((state_r == SMC_RUN) && dbg_bgnd_cmd_in && debug_mode_enable_in);
      grant_r <= dbg_mem_cmd_in && (state_r == SMC_RUN);
      dbg_err_r <= dbg_mem_cmd_in && (state_r != SMC_RUN);
    end
  end

  // ---------------------------------------------------------------
  // AHB-Lite register slave
  // ---------------------------------------------------------------
  // Zero wait state, so ready and response never change
  assign addr_ok = hsel_in && htrans_in[1] && hready_in;

  always_comb begin
    rd_word = 32'h0000_0000;
    if (reg_hit(haddr_in[7:0], OFS_CTRL)) begin
      rd_word[CTRL_W-1:0] = ctrl_r;
    end else if (reg_hit(haddr_in[7:0], OFS_PWR2)) begin
      rd_word[PWR2_SEL] = pd_sel_r;
      rd_word[PWR2_FLAG] = pd_flag_r;
    end else if (reg_hit(haddr_in[7:0], OFS_STATUS)) begin
      rd_word[STAT_LIGHT] = state_r == SMC_LIGHT;
      rd_word[STAT_DEEP] = state_r == SMC_DEEP;
      rd_word[STAT_LATCH] = pin_latch_r;
      rd_word[STAT_REG] = reg_keep_r;
      rd_word[STAT_DBG] = dbg_keep_r;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      hreadyout_r <= 1'b1;
      hresp_r <= 1'b0;
      hrdata_r <= 32'h0000_0000;
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end else begin
      hreadyout_r <= 1'b1;
      hresp_r <= 1'b0;
      wr_pend_r <= addr_ok && hwrite_in;
      if (addr_ok) begin
        wr_addr_r <= haddr_in[7:0];
        hrdata_r <= hwrite_in ? 32'h0000_0000 : rd_word;
      end
    end
  end

  assign ctrl_wr = wr_pend_r && reg_hit(wr_addr_r, OFS_CTRL);
  assign pwr2_wr = wr_pend_r && reg_hit(wr_addr_r, OFS_PWR2);
  assign ack_wr = pwr2_wr && hwdata_in[PWR2_ACK];

  // Deep wake restores reset values, low trip point
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_r <= CTRL_RST;
      pd_sel_r <= 1'b0;
    end else if (deep_wake) begin
      ctrl_r <= CTRL_RST;
      pd_sel_r <= 1'b0;
    end else begin
      if (ctrl_wr) begin
        ctrl_r <= hwdata_in[CTRL_W-1:0];
      end
      if (pwr2_wr) begin
        pd_sel_r <= hwdata_in[PWR2_SEL];
      end
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign hreadyout_out = hreadyout_r;
  assign hresp_out = hresp_r;
  assign hrdata_out = hrdata_r;
  assign pin_ctrl_out = pin_ctrl_r;
  assign pin_latch_out = pin_latch_r;
  assign bus_clk_run_out = bus_clk_r;
  assign cpu_clk_run_out = cpu_clk_r;
  assign periph_clk_run_out = periph_clk_r;
  assign debug_clk_run_out = dbg_clk_r;
  assign regulator_active_out = reg_act_r;
  assign adc_run_out = adc_run_r;
  assign ref_clk_run_out = ref_run_r;
  assign power_down_out = pdown_r;
  assign illegal_reset_out = illegal_r;
  assign sys_reset_out = sys_rst_r;
  assign por_reset_out = por_r;
  assign irq_wake_out = irq_wake_r;
  assign bkgd_enter_out = bkgd_r;
  assign dbg_mem_grant_out = grant_r;
  assign dbg_err_out = dbg_err_r;
  assign lvd_reset_en_out = ctrl_r[CTRL_LVD_RST];
  assign lvd_trip_sel_out = ctrl_r[CTRL_TRIP_SEL];

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  sequence run_stop_s;
    state_r == SMC_RUN && stop_exec_in && ctrl_r[CTRL_STOP_EN] && !debug_mode_enable_in;
  endsequence

  illegal_stop_a: assert property ((state_r == SMC_RUN && stop_exec_in
    && !ctrl_r[CTRL_STOP_EN]) |=> illegal_reset_out && state_r == SMC_RUN)
    else $error("disabled stop not refused");
  dbg_light_a: assert property ((state_r == SMC_RUN && stop_exec_in
    && ctrl_r[CTRL_STOP_EN] && debug_mode_enable_in)
    |=> state_r == SMC_LIGHT && debug_clk_run_out && regulator_active_out)
    else $error("debug stop not light with clocks");
  reg_light_a: assert property ((run_stop_s and ##0 lvd_stop_on)
    |=> state_r == SMC_LIGHT && regulator_active_out)
    else $error("regulator not kept");
  deep_sel_a: assert property ((run_stop_s and ##0 (!ctrl_r[CTRL_LOW_VOLTAGE_DETECT_STOP_ENABLE] && pd_sel_r))
    |=> state_r == SMC_DEEP && pin_latch_out && power_down_out)
    else $error("deep stop not entered");
  clk_halt_a: assert property (state_r != SMC_RUN
    |-> !bus_clk_run_out && !cpu_clk_run_out && !periph_clk_run_out)
    else $error("clock running in stop");
  light_wake_a: assert property ((state_r == SMC_LIGHT && any_irq && !pin_evt)
    |=> state_r == SMC_RUN && irq_wake_out && !sys_reset_out)
    else $error("light stop interrupt exit wrong");
  deep_hold_a: assert property ((state_r == SMC_DEEP && !pin_evt
    && !(wake_irq_in[IRQ_RTC] && ctrl_r[CTRL_RTC_EN])) |=> state_r == SMC_DEEP)
    else $error("deep stop left without cause");
  // Flag and latch held until acknowledge
  flag_hold_a: assert property ((pd_flag_r && !ack_wr)
    |=> pd_flag_r && (pin_latch_out || !$past(pin_latch_out)))
    else $error("flag dropped without ack");
  deep_por_a: assert property (deep_wake |=> por_reset_out && pd_flag_r
    && ctrl_r == CTRL_RST) else $error("deep wake not power-on like");
  dbg_err_a: assert property ((dbg_mem_cmd_in && state_r != SMC_RUN)
    |=> dbg_err_out && !dbg_mem_grant_out) else $error("memory command not refused");
  pin_freeze_a: assert property (pin_latch_out |=> $stable(pin_ctrl_out))
    else $error("latched pin changed");
  level_fix_a: assert property ((state_r != SMC_RUN && $past(state_r) != SMC_RUN)
    |-> $stable(level_r)) else $error("stop level changed in stop");
endmodule

//--- rtl/smc_sync.sv
// Two-stage synchroniser for the external reset pin
`timescale 1ns/100ps
module smc_sync (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic d_in,
  output logic q_out
);
  import smc_pkg::*;
  logic meta_r;
  logic sync_r;

  // Idle level is high, so reset to the released pin level
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta_r <= SYNC_RST;
      sync_r <= SYNC_RST;
    end else begin
      meta_r <= d_in;
      sync_r <= meta_r;
    end
  end

  assign q_out = sync_r;
endmodule

//--- tb/smc_cpu_model.sv
// CPU, wake source and debug partner model
`timescale 1ns/100ps
module smc_cpu_model
  import smc_pkg::*;
(
  input wire logic clk_in,
  output logic stop_exec_out,
  output logic [smc_pkg::WAKE_W-1:0] wake_irq_out,
  output logic dbg_mem_out,
  output logic dbg_bgnd_out,
  output logic dbg_en_out,
  output logic reset_pin_n_out
);
  initial begin
    {stop_exec_out, dbg_mem_out, dbg_bgnd_out, wake_irq_out} = '0;
    dbg_en_out = 1'b0;
    reset_pin_n_out = 1'b1;
  end
  // One-cycle request pulses, same clock
  task automatic kick(input logic [8:0] v);
    @(posedge clk_in);
    {stop_exec_out, dbg_mem_out, dbg_bgnd_out, wake_irq_out} <= v;
    @(posedge clk_in);
    {stop_exec_out, dbg_mem_out, dbg_bgnd_out, wake_irq_out} <= '0;
  endtask
  // Pin has a pull-up, so release means high
  task automatic pin_reset();
    @(posedge clk_in);
    reset_pin_n_out <= 1'b0;
    repeat (2) @(posedge clk_in);
    reset_pin_n_out <= 1'b1;
  endtask
endmodule

//--- tb/stop_mode_controller_tb_top.sv
// Self-checking bench for the stop mode controller
`timescale 1ns/100ps
module stop_mode_controller_tb_top;
  import smc_pkg::*;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic hsel = 1'b0, hwrite = 1'b0, hrdy, hresp, stp, dben, pin_n, mem, bgd;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h0;
  logic o_latch, o_bus, o_cpu, o_per, o_dbg, o_reg, o_pd, o_adc, o_ref;
  logic o_ill, o_srst, o_por, o_irq, o_bkg, o_gnt, o_err, o_lvr, o_trip;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, q;
  logic [5:0] wk;
  logic [7:0] pin_in = 8'h00, pin_out;
  logic [6:0] pls, lv;
  logic [1:0] lvd, ar;
  int error_cnt = 0, num_checks = 0, cyc = 0;
  always #5 clk_in = ~clk_in;
  smc_cpu_model cpu (.clk_in(clk_in), .stop_exec_out(stp), .wake_irq_out(wk),
    .dbg_mem_out(mem), .dbg_bgnd_out(bgd), .dbg_en_out(dben), .reset_pin_n_out(pin_n));
  smc_stop_ctrl dut (.clk_in(clk_in), .rst_in(rst_in), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
    .hready_in(hrdy), .hreadyout_out(hrdy), .hresp_out(hresp), .hrdata_out(hrdata),
    .stop_exec_in(stp), .debug_mode_enable_in(dben), .reset_pin_n_in(pin_n),
    .wake_irq_in(wk), .dbg_mem_cmd_in(mem), .dbg_bgnd_cmd_in(bgd), .pin_ctrl_in(pin_in),
    .pin_ctrl_out(pin_out), .pin_latch_out(o_latch), .bus_clk_run_out(o_bus),
    .cpu_clk_run_out(o_cpu), .periph_clk_run_out(o_per), .debug_clk_run_out(o_dbg),
    .regulator_active_out(o_reg), .adc_run_out(o_adc), .ref_clk_run_out(o_ref),
    .power_down_out(o_pd), .illegal_reset_out(o_ill), .sys_reset_out(o_srst),
    .por_reset_out(o_por), .irq_wake_out(o_irq), .bkgd_enter_out(o_bkg),
    .dbg_mem_grant_out(o_gnt), .dbg_err_out(o_err), .lvd_reset_en_out(o_lvr),
    .lvd_trip_sel_out(o_trip));
  assign lv = {o_bus, o_cpu, o_per, o_dbg, o_reg, o_pd, o_latch};
  assign ar = {o_adc, o_ref};
  assign pls = {o_ill, o_srst, o_por, o_irq, o_bkg, o_gnt, o_err};
  assign lvd = {o_lvr, o_trip};
  // ---------------------------------------------------------------
  // Checking and bus tasks
  // ---------------------------------------------------------------
  task automatic test_done();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Master holds each phase until hready is seen high
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    @(posedge clk_in);
    while (hrdy !== 1'b1) @(posedge clk_in);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk_in);
    while (hrdy !== 1'b1) @(posedge clk_in);
    q = hrdata;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
    ahb(1'b0, a, 32'h0);
    chk(nm, q, exp);
    chk("response", {31'h0, hresp}, 32'h0);
  endtask
  // Pulses last one cycle, so look after every edge, the launching one too
  task automatic wait_pulse(input int b, input string nm);
    int n;
    n = 0;
    #1;
    while (pls[b] !== 1'b1 && n < 8) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    chk(nm, {31'h0, pls[b]}, 32'h1);
  endtask
  task automatic lvl(input logic [6:0] exp);
    repeat (2) @(posedge clk_in);
    #1;
    chk("levels", {25'h0, lv}, {25'h0, exp});
  endtask
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      error_cnt++;
      test_done();
    end
  end
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk_in);
    rst_in <= 1'b0;
    rd(OFS_CTRL, 32'h00e, "control reset");
    cpu.kick(9'h100);
    wait_pulse(6, "illegal reset");
    lvl(7'b1111100);
    ahb(1'b1, OFS_CTRL, 32'h001);
    ahb(1'b1, OFS_PWR2, 32'h000);
    pin_in <= 8'ha5;
    cpu.kick(9'h100);
    lvl(7'b0000000);
    pin_in <= 8'h3c;
    cpu.dbg_en_out <= 1'b1;
    lvl(7'b0000000);
    chk("pins held", {24'h0, pin_out}, 32'ha5);
    cpu.dbg_en_out <= 1'b0;
    cpu.kick(9'h008);
    wait_pulse(3, "irq wake");
    lvl(7'b1111100);
    cpu.kick(9'h100);
    cpu.pin_reset();
    wait_pulse(5, "pin reset");
    ahb(1'b1, OFS_CTRL, 32'h0e7);
    ahb(1'b1, OFS_PWR2, 32'h001);
    cpu.kick(9'h100);
    lvl(7'b0000100);
    chk("adc ref", {30'h0, ar}, 32'h3);
    cpu.kick(9'h020);
    wait_pulse(3, "irq wake pins");
    ahb(1'b1, OFS_CTRL, 32'h005);
    cpu.kick(9'h100);
    lvl(7'b0000000);
    chk("adc ref off", {30'h0, ar}, 32'h0);
    cpu.kick(9'h002);
    wait_pulse(3, "irq wake lvd");
    ahb(1'b1, OFS_CTRL, 32'h001);
    cpu.dbg_en_out <= 1'b1;
    cpu.kick(9'h100);
    lvl(7'b0001100);
    cpu.kick(9'h080);
    wait_pulse(0, "status error");
    cpu.kick(9'h040);
    wait_pulse(2, "background");
    lvl(7'b1111100);
    cpu.kick(9'h040);
    wait_pulse(2, "background run");
    cpu.dbg_en_out <= 1'b0;
    cpu.kick(9'h080);
    wait_pulse(1, "mem grant");
    ahb(1'b1, OFS_CTRL, 32'h101);
    pin_in <= 8'h5a;
    cpu.kick(9'h100);
    lvl(7'b0000011);
    pin_in <= 8'hff;
    cpu.kick(9'h008);
    lvl(7'b0000011);
    cpu.kick(9'h001);
    wait_pulse(4, "por wake");
    lvl(7'b1111101);
    chk("pins latched", {24'h0, pin_out}, 32'h5a);
    rd(OFS_CTRL, 32'h00e, "control after wake");
    chk("lvd bits", {30'h0, lvd}, 32'h2);
    rd(OFS_PWR2, 32'h002, "flag set");
    rd(OFS_STATUS, 32'h004, "status latched");
    pin_in <= 8'h96;
    ahb(1'b1, OFS_PWR2, 32'h004);
    lvl(7'b1111100);
    chk("pins released", {24'h0, pin_out}, 32'h96);
    rd(OFS_PWR2, 32'h000, "flag clear");
    test_done();
  end
endmodule
